//--- fmc_host_model.sv
// Wishbone host model issuing setting commands and queries
`timescale 1ns/1ns
module fmc_host_model (
    // Clock and answer
    input wire clk_i,
    input wire ack_i,
    input wire [31:0] rdat_i,
    // Request
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    // Idle bus from time zero
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0000_0000;
    end
    // One classic cycle; the wait has no limit of its own
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= 4'hF;
        dat_o <= d;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = rdat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= 1'b0;
        // Released data must not look like the last word
        dat_o <= ~d;
    endtask
endmodule

//--- fmc_regs.vh
// Register map, field positions, reset values and limits of the checker
// Contract
// - Deviation up to 7.5 MHz, default 100 Hz
// - FM on: deviation above carrier clamps, logs -221
// - Carrier plus deviation within fmax plus 100 kHz
// - Modulating rate 10 kHz max, default 10 Hz
// - Modulating shape selectable; noise and dc never carriers
// - One modulation mode; enabling one disables others
// - State query answers 0 off, 1 on
// - Output frequency default 1 kHz, limited per function
// - Min/max keyword gives limits of active function
// - Arbitrary maximum frequency depends on point count
// - Function change clamps frequency, logs -221
// - Sweep start 15 MHz max, default 100 Hz
// - Sweep stop 15 MHz max, default 1 kHz
// - Sweep frequency steps keep phase continuous
// - Hop frequency 15 MHz max, default 100 Hz
// - Internal keying alternates carrier and hop at rate
// - Keying rate ignored with external keying source
// - Queries return stored value or min/max limit
// - External keying: low carrier, high hop frequency
`ifndef FMC_REGS_VH
`define FMC_REGS_VH

// Word indices, byte address is index times four
`define FMC_IDX_CTRL 4'h0
`define FMC_IDX_FUNC 4'h1
`define FMC_IDX_FREQ 4'h2
`define FMC_IDX_DEV 4'h3
`define FMC_IDX_MRATE 4'h4
`define FMC_IDX_MSHAPE 4'h5
`define FMC_IDX_START 4'h6
`define FMC_IDX_STOP 4'h7
`define FMC_IDX_HOP 4'h8
`define FMC_IDX_SRATE 4'h9
`define FMC_IDX_ARBPTS 4'hA
`define FMC_IDX_STATUS 4'hB
`define FMC_IDX_ERR 4'hC

// Keyword field in address bits 7:6
`define FMC_KEY_VAL 2'h0
`define FMC_KEY_MIN 2'h1
`define FMC_KEY_MAX 2'h2

// Control register fields
`define FMC_CTRL_MODE_LSB 0
`define FMC_CTRL_SRC_BIT 5
`define FMC_MODE_AM 5'h01
`define FMC_MODE_FM 5'h02
`define FMC_MODE_BURST 5'h04
`define FMC_MODE_FSK 5'h08
`define FMC_MODE_SWEEP 5'h10

// Shape codes
`define FMC_SH_SIN 3'h0
`define FMC_SH_SQU 3'h1
`define FMC_SH_TRI 3'h2
`define FMC_SH_RAMP 3'h3
`define FMC_SH_NOISE 3'h4
`define FMC_SH_DC 3'h5
`define FMC_SH_USER 3'h6

// Status bits
`define FMC_ST_CONFLICT 0
`define FMC_ST_BADSHAPE 1
`define FMC_ERR_CONFLICT 32'hFFFF_FF23

// Frequencies in units of 10 mHz
`define FMC_F_MIN 31'h0000_0001
`define FMC_F_100HZ 31'h0000_2710
`define FMC_F_1KHZ 31'h0001_86A0
`define FMC_F_10HZ 31'h0000_03E8
`define FMC_F_10KHZ 31'h000F_4240
`define FMC_F_50KHZ 31'h004C_4B40
`define FMC_F_100KHZ 31'h0098_9680
`define FMC_F_200KHZ 31'h0131_2D00
`define FMC_F_2M5HZ 31'h0EE6_B280
`define FMC_F_5MHZ 31'h1DCD_6500
`define FMC_F_7M5HZ 31'h2CB4_1780
`define FMC_F_15MHZ 31'h5968_2F00
`define FMC_F_CLK 32'h3B9A_CA00

// Arbitrary point tiers
`define FMC_PTS_T1 14'h2000
`define FMC_PTS_T2 14'h2FFF
`define FMC_PTS_MAX 14'h3E80

`endif

//--- fmc_setting_checker.v
// Frequency, FM, sweep and keying setting checker with Wishbone access
`timescale 1ns/1ns
`include "fmc_regs.vh"

module fmc_setting_checker (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // External keying level
    input wire key_trig_i,
    // Synthesizer side
    output reg [30:0] freq_sel_o,
    output reg hop_active_o,
    output reg [4:0] mode_en_o,
    output reg conflict_pulse_o
);

    // Stored settings
    reg [4:0] mode_ff; // One-hot active modulation mode
    reg src_ext_ff; // Keying source, high for external
    reg [2:0] shape_ff; // Carrier shape
    reg [30:0] freq_ff; // Carrier frequency
    reg [30:0] dev_ff; // Peak deviation
    reg [30:0] mrate_ff; // Modulating frequency
    reg [2:0] mshape_ff; // Modulating shape
    reg [30:0] start_ff; // Sweep start
    reg [30:0] stop_ff; // Sweep stop
    reg [30:0] hop_ff; // Hop frequency
    reg [30:0] srate_ff; // Internal keying rate
    reg [13:0] pts_ff; // Arb point count, zero for built-in
    reg [1:0] status_ff; // Sticky error flags
    reg [31:0] acc_ff; // Keying phase accumulator
    reg tog_ff; // Internal keying selector

    // Combinational helpers
    reg [31:0] rd_val;
    reg [30:0] lo;
    reg [30:0] hi;
    reg [31:0] w;
    reg [30:0] cv;
    reg [30:0] nxt_freq;
    reg [30:0] nxt_dev;
    reg [4:0] nxt_mode;
    reg [2:0] nxt_shape;
    reg nxt_conf;
    reg nxt_bad;
    reg [31:0] nxt_acc;
    reg nxt_tog;
    reg [31:0] sum;
    reg [30:0] lim;
    reg [30:0] fm_new;
    reg [4:0] new_on;

    // Bus access in progress
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr = req & wb_we_i;
    wire [3:0] idx = wb_adr_i[5:2];
    wire [1:0] key = wb_adr_i[7:6];
    wire fsk_on = mode_ff[3];

    // Highest carrier frequency for a shape and point count
    function [30:0] fmax_of;
        input [2:0] sh;
        input [13:0] pts;
        begin
            case (sh)
                `FMC_SH_TRI, `FMC_SH_RAMP: fmax_of = `FMC_F_100KHZ;
                `FMC_SH_USER: begin
                    // Built-in shapes and small tables share 5 MHz
                    if (pts <= `FMC_PTS_T1)
                        fmax_of = `FMC_F_5MHZ;
                    else if (pts <= `FMC_PTS_T2)
                        fmax_of = `FMC_F_2M5HZ;
                    else
                        fmax_of = `FMC_F_200KHZ;
                end
                default: fmax_of = `FMC_F_15MHZ;
            endcase
        end
    endfunction

    // Highest sweep and hop frequency for a shape
    function [30:0] smax_of;
        input [2:0] sh;
        begin
            if (sh == `FMC_SH_TRI || sh == `FMC_SH_RAMP)
                smax_of = `FMC_F_100KHZ;
            else
                smax_of = `FMC_F_15MHZ;
        end
    endfunction

    // Clamp a value into a range
    function [30:0] clampf;
        input [30:0] v;
        input [30:0] l;
        input [30:0] h;
        begin
            if (v < l)
                clampf = l;
            else if (v > h)
                clampf = h;
            else
                clampf = v;
        end
    endfunction

    // Merge write data into a word under byte enables
    function [31:0] merge;
        input [31:0] old;
        input [31:0] dat;
        input [3:0] sel;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i])
                    merge[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
    endfunction

    // Stored value and limits of the addressed register
    always @* begin
        // Limits start at the sweep range; words without limits ignore them
        lo = `FMC_F_MIN;
        hi = `FMC_F_15MHZ;
        case (idx)
            `FMC_IDX_CTRL: begin
                // Each mode bit reads 0 when off and 1 when on
                rd_val = {26'h000_0000, src_ext_ff, mode_ff};
            end
            `FMC_IDX_FUNC: rd_val = {29'h0000_0000, shape_ff};
            `FMC_IDX_FREQ: begin
                rd_val = {1'b0, freq_ff};
                hi = fmax_of(shape_ff, pts_ff);
            end
            `FMC_IDX_DEV: begin
                rd_val = {1'b0, dev_ff};
                hi = `FMC_F_7M5HZ;
            end
            `FMC_IDX_MRATE: begin
                rd_val = {1'b0, mrate_ff};
                hi = `FMC_F_10KHZ;
            end
            `FMC_IDX_MSHAPE: rd_val = {29'h0000_0000, mshape_ff};
            `FMC_IDX_START: begin
                rd_val = {1'b0, start_ff};
                hi = smax_of(shape_ff);
            end
            `FMC_IDX_STOP: begin
                rd_val = {1'b0, stop_ff};
                hi = smax_of(shape_ff);
            end
            `FMC_IDX_HOP: begin
                rd_val = {1'b0, hop_ff};
                hi = smax_of(shape_ff);
            end
            `FMC_IDX_SRATE: begin
                rd_val = {1'b0, srate_ff};
                hi = `FMC_F_50KHZ;
            end
            `FMC_IDX_ARBPTS: rd_val = {18'h0_0000, pts_ff};
            `FMC_IDX_STATUS: rd_val = {30'h0000_0000, status_ff};
            `FMC_IDX_ERR: begin
                // Last error code while the conflict flag stands
                if (status_ff[`FMC_ST_CONFLICT])
                    rd_val = `FMC_ERR_CONFLICT;
                else
                    rd_val = 32'h0000_0000;
            end
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // Candidate values and conflict checks for a write
    always @* begin
        w = merge(rd_val, wb_dat_i, wb_sel_i);
        // Keyword addresses substitute the limit for the data
        case (key)
            `FMC_KEY_MIN: cv = lo;
            `FMC_KEY_MAX: cv = hi;
            default: cv = clampf(w[30:0], lo, hi);
        endcase
        nxt_conf = 1'b0;
        nxt_bad = 1'b0;
        nxt_freq = freq_ff;
        nxt_dev = dev_ff;
        nxt_shape = shape_ff;
        nxt_mode = mode_ff;
        sum = 32'h0000_0000;
        lim = 31'h0000_0000;
        fm_new = fmax_of(shape_ff, pts_ff);
        new_on = 5'h00;
        if (wr && idx == `FMC_IDX_FREQ)
            nxt_freq = cv;
        if (wr && idx == `FMC_IDX_DEV) begin
            // Room left under the function max plus 100 kHz
            sum = {1'b0, fm_new} + {1'b0, `FMC_F_100KHZ};
            lim = sum[30:0] - freq_ff;
            // A carrier left above the ceiling by a point count change
            // would wrap the room; give it the smallest legal value
            if (freq_ff > sum[30:0])
                lim = `FMC_F_MIN;
            // With FM on the carrier bounds the deviation too
            if (mode_ff[1] && freq_ff < lim)
                lim = freq_ff;
            if (cv > lim) begin
                nxt_dev = lim;
                nxt_conf = 1'b1;
            end else begin
                nxt_dev = cv;
            end
        end
        if (wr && idx == `FMC_IDX_FUNC) begin
            if (w[2:0] == `FMC_SH_NOISE || w[2:0] == `FMC_SH_DC ||
                w[2:0] > `FMC_SH_USER) begin
                // Refused carrier shape leaves the old one in place
                nxt_bad = 1'b1;
            end else begin
                nxt_shape = w[2:0];
                fm_new = fmax_of(w[2:0], pts_ff);
                if (freq_ff > fm_new) begin
                    nxt_freq = fm_new;
                    nxt_conf = 1'b1;
                end
            end
        end
        if (wr && idx == `FMC_IDX_CTRL) begin
            // A newly enabled mode wins; others may only be cleared
            new_on = w[4:0] & ~mode_ff;
            if (new_on != 5'h00)
                nxt_mode = new_on & (~new_on + 5'h01);
            else
                nxt_mode = w[4:0] & mode_ff;
        end
    end

    // Internal keying accumulator, two shifts per rate period
    always @* begin
        nxt_acc = acc_ff;
        nxt_tog = tog_ff;
        if (fsk_on && !src_ext_ff) begin
            // Rate only matters with the internal source
            nxt_acc = acc_ff + {srate_ff[30:0], 1'b0};
            // One step is far below the wrap value, one subtraction suffices
            if (nxt_acc >= `FMC_F_CLK) begin
                nxt_acc = nxt_acc - `FMC_F_CLK;
                nxt_tog = ~tog_ff;
            end
        end else begin
            nxt_acc = 32'h0000_0000;
            nxt_tog = 1'b0;
        end
    end

    // Setting storage, reset brings back the defaults
    always @(posedge clk_i) begin
        if (rst_i) begin
            mode_ff <= 5'h00;
            src_ext_ff <= 1'b0;
            shape_ff <= `FMC_SH_SIN;
            freq_ff <= `FMC_F_1KHZ;
            dev_ff <= `FMC_F_100HZ;
            mrate_ff <= `FMC_F_10HZ;
            mshape_ff <= `FMC_SH_SIN;
            start_ff <= `FMC_F_100HZ;
            stop_ff <= `FMC_F_1KHZ;
            hop_ff <= `FMC_F_100HZ;
            srate_ff <= `FMC_F_10HZ;
            pts_ff <= 14'h0000;
            status_ff <= 2'h0;
            acc_ff <= 32'h0000_0000;
            tog_ff <= 1'b0;
        end else begin
            freq_ff <= nxt_freq;
            dev_ff <= nxt_dev;
            shape_ff <= nxt_shape;
            mode_ff <= nxt_mode;
            acc_ff <= nxt_acc;
            tog_ff <= nxt_tog;
            // Plain settings: the write edge commits the clamped value
            if (wr) begin
                case (idx)
                    `FMC_IDX_CTRL: src_ext_ff <= w[`FMC_CTRL_SRC_BIT];
                    `FMC_IDX_MRATE: mrate_ff <= cv;
                    `FMC_IDX_MSHAPE: begin
                        // Noise is fine as a modulating shape
                        if (w[2:0] != `FMC_SH_DC && w[2:0] <= `FMC_SH_USER)
                            mshape_ff <= w[2:0];
                    end
                    `FMC_IDX_START: start_ff <= cv;
                    `FMC_IDX_STOP: stop_ff <= cv;
                    `FMC_IDX_HOP: hop_ff <= cv;
                    `FMC_IDX_SRATE: srate_ff <= cv;
                    `FMC_IDX_ARBPTS: begin
                        // Counts beyond the largest tier are cut to it
                        if (w[13:0] > `FMC_PTS_MAX)
                            pts_ff <= `FMC_PTS_MAX;
                        else
                            pts_ff <= w[13:0];
                    end
                    default: begin
                    end
                endcase
            end
            // Set wins over the write-one-to-clear
            status_ff[`FMC_ST_CONFLICT] <= nxt_conf |
                (status_ff[`FMC_ST_CONFLICT] &
                 ~(wr && idx == `FMC_IDX_STATUS && wb_sel_i[0] &&
                   wb_dat_i[`FMC_ST_CONFLICT]));
            status_ff[`FMC_ST_BADSHAPE] <= nxt_bad |
                (status_ff[`FMC_ST_BADSHAPE] &
                 ~(wr && idx == `FMC_IDX_STATUS && wb_sel_i[0] &&
                   wb_dat_i[`FMC_ST_BADSHAPE]));
        end
    end

    // Bus answer: one wait state, unmapped words read zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (req && !wb_we_i) begin
                // Limit queries on the frequency words
                if (key == `FMC_KEY_MIN && idx >= `FMC_IDX_FREQ &&
                    idx <= `FMC_IDX_SRATE && idx != `FMC_IDX_MSHAPE)
                    wb_dat_o <= {1'b0, lo};
                else if (key == `FMC_KEY_MAX && idx >= `FMC_IDX_FREQ &&
                    idx <= `FMC_IDX_SRATE && idx != `FMC_IDX_MSHAPE)
                    wb_dat_o <= {1'b0, hi};
                else
                    wb_dat_o <= rd_val;
            end else begin
                // Zero outside the answer keeps stale words off the bus
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // Synthesizer outputs; the frequency word changes in place and no
    // phase reset is ever issued, so the synthesizer stays continuous
    always @(posedge clk_i) begin
        if (rst_i) begin
            freq_sel_o <= `FMC_F_1KHZ;
            hop_active_o <= 1'b0;
            mode_en_o <= 5'h00;
            conflict_pulse_o <= 1'b0;
        end else begin
            mode_en_o <= mode_ff;
            // One pulse per conflicting write, in the ack cycle
            conflict_pulse_o <= nxt_conf;
            if (fsk_on && (src_ext_ff ? key_trig_i : tog_ff)) begin
                hop_active_o <= 1'b1;
                freq_sel_o <= hop_ff;
            end else begin
                hop_active_o <= 1'b0;
                freq_sel_o <= freq_ff;
            end
        end
    end

endmodule

//--- fmc_setting_checker_monitor.sv
// Bus timing and output checks for the setting checker
`timescale 1ns/1ns
`include "fmc_regs.vh"
module fmc_setting_checker_monitor (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave side
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // Keying and synthesizer side
    input wire key_trig_i,
    input wire [30:0] freq_sel_o,
    input wire hop_active_o,
    input wire [4:0] mode_en_o,
    input wire conflict_pulse_o
);
    // Word index of the request on the bus
    wire [3:0] adr_idx = wb_adr_i[5:2];
    // A request that the slave takes on this edge
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // One answer cycle, then quiet even if the strobe lingers
    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_one_pulse: assert property (s_take |=> s_answer)
        else $error("ack not one pulse one cycle after request");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_mode_one_hot: assert property ($onehot0(mode_en_o))
        else $error("more than one mode enabled");
    // Reset itself is the cause here, so it cannot disable the check
    a_reset_restores: assert property (disable iff (1'b0)
        rst_i |=> freq_sel_o == `FMC_F_1KHZ && mode_en_o == 5'h00
        && !hop_active_o && !conflict_pulse_o)
        else $error("outputs not at defaults after reset");
    a_conflict_on_write: assert property (conflict_pulse_o
        |-> wb_ack_o && $past(wb_we_i))
        else $error("conflict pulse without a write answer");
    a_freq_in_range: assert property (freq_sel_o >= 31'h0000_0001
        && freq_sel_o <= `FMC_F_15MHZ)
        else $error("frequency outside legal range");
    a_mode_by_ctrl: assert property ($changed(mode_en_o)
        |-> $past(wb_ack_o) && $past(adr_idx) == `FMC_IDX_CTRL)
        else $error("mode changed without a control write");
    a_freq_has_cause: assert property ($changed(freq_sel_o)
        |-> $past(wb_ack_o) || $changed(hop_active_o))
        else $error("frequency changed without cause");
endmodule

bind fmc_setting_checker fmc_setting_checker_monitor u_mon (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .key_trig_i(key_trig_i),
    .freq_sel_o(freq_sel_o), .hop_active_o(hop_active_o),
    .mode_en_o(mode_en_o), .conflict_pulse_o(conflict_pulse_o)
);

//--- fmc_setting_checker_tb.sv
// Self-checking bench for the setting checker
`timescale 1ns/1ns
`include "fmc_regs.vh"
module fmc_setting_checker_tb;
    // One access: write flag, address, data or expected read
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [31:0] v;
    } fmc_row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic key_trig_i = 1'b0;
    wire cyc, stb, we, ack, hop, conf;
    wire [7:0] adr;
    wire [3:0] sel;
    wire [31:0] wdat, rdat;
    wire [30:0] freq;
    wire [4:0] mode;
    int num_errors = 0;
    int n_checks = 0;
    int n_conf = 0;
    int t;
    // Defaults, limits, clamps and refused shapes
    fmc_row_t rows [32] = '{
        '{1'b0, 8'h00, 32'h0000_0000}, '{1'b0, 8'h08, 32'h0001_86A0},
        '{1'b0, 8'h0C, 32'h0000_2710}, '{1'b0, 8'h10, 32'h0000_03E8},
        '{1'b0, 8'h14, 32'h0000_0000}, '{1'b0, 8'h18, 32'h0000_2710},
        '{1'b0, 8'h1C, 32'h0001_86A0}, '{1'b0, 8'h20, 32'h0000_2710},
        '{1'b0, 8'h24, 32'h0000_03E8}, '{1'b0, 8'h4C, 32'h0000_0001},
        '{1'b0, 8'h8C, 32'h2CB4_1780}, '{1'b0, 8'h90, 32'h000F_4240},
        '{1'b0, 8'h88, 32'h5968_2F00}, '{1'b0, 8'h98, 32'h5968_2F00},
        '{1'b0, 8'hA0, 32'h5968_2F00}, '{1'b0, 8'hA4, 32'h004C_4B40},
        '{1'b0, 8'h34, 32'h0000_0000}, '{1'b1, 8'h0C, 32'h0000_0000},
        '{1'b0, 8'h0C, 32'h0000_0001}, '{1'b1, 8'h10, 32'h0131_2D00},
        '{1'b0, 8'h10, 32'h000F_4240}, '{1'b1, 8'h14, 32'h0000_0005},
        '{1'b0, 8'h14, 32'h0000_0000}, '{1'b1, 8'h04, 32'h0000_0004},
        '{1'b0, 8'h04, 32'h0000_0000}, '{1'b0, 8'h2C, 32'h0000_0002},
        '{1'b1, 8'h28, 32'h0000_3FFF}, '{1'b0, 8'h28, 32'h0000_3E80},
        '{1'b1, 8'h04, 32'h0000_0006}, '{1'b0, 8'h88, 32'h0131_2D00},
        '{1'b1, 8'h28, 32'h0000_2000}, '{1'b0, 8'h88, 32'h1DCD_6500}
    };

    // Clock at 100 ns period
    always #50 clk_i = ~clk_i;

    // Count conflict pulses seen on the synthesizer side
    always @(posedge clk_i)
        if (conf === 1'b1)
            n_conf <= n_conf + 1;

    fmc_host_model u_host (
        .clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat)
    );

    fmc_setting_checker DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .key_trig_i(key_trig_i),
        .freq_sel_o(freq), .hop_active_o(hop), .mode_en_o(mode),
        .conflict_pulse_o(conf)
    );

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Compare one value, report and count
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        u_host.xfer(1'b1, a, d, r);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        u_host.xfer(1'b0, a, 32'h0000_0000, r);
        chk("read", e, r);
    endtask

    // Let registered outputs land before sampling
    task automatic settle();
        repeat (3) @(negedge clk_i);
    endtask

    // Cycles until the hop level next changes, bounded
    task automatic gap();
        logic p;
        p = hop;
        t = 0;
        while (hop === p && t < 1000) begin
            @(negedge clk_i);
            t++;
        end
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].w)
                wr(rows[i].a, rows[i].v);
            else
                rdc(rows[i].a, rows[i].v);
        end
        // Triangle lowers a 200 kHz carrier to its own ceiling
        wr(8'h08, 32'h0131_2D00);
        wr(8'h04, 32'h0000_0002);
        rdc(8'h08, 32'h0098_9680);
        settle();
        chk("freq_sel", 32'h0098_9680, {1'b0, freq});
        chk("conflicts", 32'h0000_0001, n_conf);
        // FM on: deviation capped by the 50 kHz carrier
        wr(8'h08, 32'h004C_4B40);
        wr(8'h00, 32'h0000_0002);
        rdc(8'h00, 32'h0000_0002);
        // Clear sticky flags so the error word proves this conflict
        wr(8'h2C, 32'h0000_0003);
        wr(8'h0C, 32'h0131_2D00);
        rdc(8'h0C, 32'h004C_4B40);
        rdc(8'h30, 32'hFFFF_FF23);
        // FM off: only the function ceiling plus 100 kHz applies
        wr(8'h00, 32'h0000_0000);
        wr(8'h0C, 32'h0131_2D00);
        rdc(8'h0C, 32'h00E4_E1C0);
        chk("conflicts", 32'h0000_0003, n_conf);
        // Enabling keying drops FM
        wr(8'h00, 32'h0000_0002);
        wr(8'h00, 32'h0000_0008);
        settle();
        chk("mode", 32'h0000_0008, {27'h0, mode});
        // Highest keying rate toggles every 100 cycles
        wr(8'hA4, 32'h0000_0000);
        gap();
        gap();
        chk("toggle gap", 32'h0000_0064, t);
        chk("hop", 32'h0000_0000, {31'h0, hop});
        chk("freq_sel", 32'h004C_4B40, {1'b0, freq});
        // External source: trigger level picks the frequency
        wr(8'h00, 32'h0000_0028);
        @(posedge clk_i) key_trig_i <= 1'b1;
        settle();
        chk("hop", 32'h0000_0001, {31'h0, hop});
        chk("freq_sel", 32'h0000_2710, {1'b0, freq});
        @(posedge clk_i) key_trig_i <= 1'b0;
        settle();
        chk("freq_sel", 32'h004C_4B40, {1'b0, freq});
        t = 0;
        repeat (300) begin
            @(negedge clk_i);
            if (hop !== 1'b0)
                t++;
        end
        chk("stray hop", 32'h0000_0000, t);
        // Burst takes over from keying and reads back as on
        wr(8'h00, 32'h0000_0004);
        rdc(8'h00, 32'h0000_0004);
        settle();
        chk("mode", 32'h0000_0004, {27'h0, mode});
        // Reset in mid-run restores defaults
        @(posedge clk_i) rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        chk("freq_sel", 32'h0001_86A0, {1'b0, freq});
        chk("mode", 32'h0000_0000, {27'h0, mode});
        rdc(8'h0C, 32'h0000_2710);
        rdc(8'h00, 32'h0000_0000);
        tally_and_finish();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        tally_and_finish();
    end
endmodule
